// *** rtl/ssf_status_flags.sv ***
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ssf_cfg.svh"

module ssf_status_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Transmit shifter side
  input wire logic tx_load_i,
  input wire logic tx_last_bit_i,
  output logic [7:0] tx_data_o,
  output logic tx_mp_bit_o,
  output logic tx_halt_o,
  // Receive shifter side
  input wire logic rx_done_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  input wire logic rx_stop1_i,
  input wire logic rx_mp_bit_i,
  output logic rx_halt_o,
  // DMA controller
  input wire logic dma_tx_write_i,
  input wire logic [7:0] dma_tx_data_i,
  input wire logic dma_rx_read_i,
  output logic [7:0] rx_data_o
);

  function automatic ssf_pkg::ssf_reg_t decode(input logic [11:0] a);
    case (a)
      `SSF_ADDR_STATUS: decode = ssf_pkg::SSF_REG_STATUS;
      `SSF_ADDR_CTRL: decode = ssf_pkg::SSF_REG_CTRL;
      `SSF_ADDR_TXD: decode = ssf_pkg::SSF_REG_TXD;
      `SSF_ADDR_RXD: decode = ssf_pkg::SSF_REG_RXD;
      default: decode = ssf_pkg::SSF_REG_NONE;
    endcase
  endfunction

  ssf_pkg::ssf_byte_t stat_q, stat_d;
  logic [`SSF_NFLAGS-1:0] qual_q, qual_d;
  logic [`SSF_NFLAGS-1:0] sw_clr, rd_mask;
  logic [`SSF_CTRL_W-1:0] ctrl_q;
  ssf_pkg::ssf_byte_t tx_hold_q, rx_hold_q;
  logic pready_q;
  logic setup, acc, rd_fire, st_wr;
  logic tx_en, rx_en, sync_md, async_md, mp_fmt;
  logic err_any, rx_take, frm_err, par_err, tx_empty_clr;
  ssf_pkg::ssf_reg_t sel;

  assign sel = decode(paddr_i);
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i & pready_q;
  assign rd_fire = acc & ~pwrite_i & (sel == ssf_pkg::SSF_REG_STATUS);
  assign st_wr = acc & pwrite_i & (sel == ssf_pkg::SSF_REG_STATUS);

  assign tx_en = ctrl_q[`SSF_CTRL_TX_EN];
  assign rx_en = ctrl_q[`SSF_CTRL_RX_EN];
  assign sync_md = ctrl_q[`SSF_CTRL_SYNC];
  assign async_md = ~sync_md;
  assign mp_fmt = async_md & ctrl_q[`SSF_CTRL_MPFMT];

  assign err_any = |stat_q[`SSF_BIT_OVERRUN:`SSF_BIT_PARITY];
  // Disabled or halted receiver drops completions, flags stay put
  assign rx_take = rx_done_i & rx_en & ~err_any;
  // Shifter reports only the first stop bit; the second is never looked at
  assign frm_err = async_md & ~rx_stop1_i;
  assign par_err = async_md & ctrl_q[`SSF_CTRL_PAREN] &
                   ((^{rx_data_i, rx_parity_i}) !=
                    ctrl_q[`SSF_CTRL_PARODD]);

  // Read as 1 arms a flag; prdata_o still holds the value being returned
  assign rd_mask = rd_fire ?
    prdata_o[`SSF_BIT_TX_EMPTY:`SSF_FLAG_LSB] : '0;

  always_comb begin
    for (int i = 0; i < `SSF_NFLAGS; i++) begin
      sw_clr[i] = st_wr & ~pwdata_i[i + `SSF_FLAG_LSB] & qual_q[i];
    end
  end

  assign tx_empty_clr = sw_clr[`SSF_BIT_TX_EMPTY - `SSF_FLAG_LSB] |
                        dma_tx_write_i;

  // Next status: clears first, then sets, so a set in the same cycle wins
  always_comb begin
    stat_d = stat_q;
    if (tx_empty_clr) begin
      stat_d[`SSF_BIT_TX_EMPTY] = 1'b0;
      stat_d[`SSF_BIT_TX_DONE] = 1'b0;
    end
    if (tx_load_i | ~tx_en) begin
      stat_d[`SSF_BIT_TX_EMPTY] = 1'b1;
    end
    if ((tx_last_bit_i & stat_q[`SSF_BIT_TX_EMPTY]) | ~tx_en) begin
      stat_d[`SSF_BIT_TX_DONE] = 1'b1;
    end
    if (sw_clr[`SSF_BIT_RX_FULL - `SSF_FLAG_LSB] | dma_rx_read_i) begin
      stat_d[`SSF_BIT_RX_FULL] = 1'b0;
    end
    for (int i = 0; i < `SSF_BIT_RX_FULL - `SSF_FLAG_LSB; i++) begin
      if (sw_clr[i]) begin
        stat_d[i + `SSF_FLAG_LSB] = 1'b0;
      end
    end
    if (rx_take & stat_q[`SSF_BIT_RX_FULL]) begin
      stat_d[`SSF_BIT_OVERRUN] = 1'b1;
    end
    if (rx_take & ~stat_q[`SSF_BIT_RX_FULL]) begin
      if (frm_err) begin
        stat_d[`SSF_BIT_FRAMING] = 1'b1;
      end
      if (par_err) begin
        stat_d[`SSF_BIT_PARITY] = 1'b1;
      end
      if (~frm_err & ~par_err) begin
        stat_d[`SSF_BIT_RX_FULL] = 1'b1;
      end
    end
    if (rx_take & mp_fmt) begin
      stat_d[`SSF_BIT_RX_MP] = rx_mp_bit_i;
    end
    // Writes copy only bit 0 directly; a qualified 0 clears flags 7..3 above, and clearing bit 7 clears bit 2 too
    if (st_wr) begin
      stat_d[`SSF_BIT_TX_MP] = pwdata_i[`SSF_BIT_TX_MP];
    end
    if (standby_i) begin
      stat_d = `SSF_STAT_RESET;
    end
  end

  // A qualifier lives only while its flag is 1; standby drops them all
  assign qual_d = standby_i ? '0 : ((qual_q | rd_mask) &
                  stat_d[`SSF_BIT_TX_EMPTY:`SSF_FLAG_LSB]);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= `SSF_STAT_RESET;
      qual_q <= '0;
    end else begin
      stat_q <= stat_d;
      qual_q <= qual_d;
    end
  end

  // Halts follow the error flags; clocked mode also stops the transmitter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_halt_o <= 1'b0;
      tx_halt_o <= 1'b0;
      tx_mp_bit_o <= 1'b0;
    end else begin
      rx_halt_o <= |stat_d[`SSF_BIT_OVERRUN:`SSF_BIT_PARITY];
      tx_halt_o <= ctrl_q[`SSF_CTRL_SYNC] &
                   (|stat_d[`SSF_BIT_OVERRUN:`SSF_BIT_PARITY]);
      tx_mp_bit_o <= mp_fmt & stat_d[`SSF_BIT_TX_MP];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `SSF_CTRL_RESET;
    end else if (acc & pwrite_i & (sel == ssf_pkg::SSF_REG_CTRL)) begin
      ctrl_q <= pwdata_i[`SSF_CTRL_W-1:0];
    end
  end

  // Holding registers; the DMA write takes priority over the CPU
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_hold_q <= `SSF_BYTE_ZERO;
      rx_hold_q <= `SSF_BYTE_ZERO;
    end else begin
      if (dma_tx_write_i) begin
        tx_hold_q <= dma_tx_data_i;
      end else if (acc & pwrite_i & (sel == ssf_pkg::SSF_REG_TXD)) begin
        tx_hold_q <= pwdata_i[7:0];
      end
      // Overrun keeps the older byte; errors still copy the new one
      if (rx_take & ~stat_q[`SSF_BIT_RX_FULL]) begin
        rx_hold_q <= rx_data_i;
      end
    end
  end

  assign tx_data_o = tx_hold_q;
  assign rx_data_o = rx_hold_q;

  // APB: data and ready are prepared in setup, so access takes one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      prdata_o <= `SSF_WORD_ZERO;
      pslverr_o <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_o <= (sel == ssf_pkg::SSF_REG_NONE);
        case (sel)
          ssf_pkg::SSF_REG_STATUS: prdata_o <= {24'h00_0000, stat_q};
          ssf_pkg::SSF_REG_CTRL: prdata_o <= {26'h000_0000, ctrl_q};
          ssf_pkg::SSF_REG_TXD: prdata_o <= {24'h00_0000, tx_hold_q};
          ssf_pkg::SSF_REG_RXD: prdata_o <= {24'h00_0000, rx_hold_q};
          default: prdata_o <= `SSF_WORD_ZERO;
        endcase
      end else if (~psel_i) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  assign pready_o = pready_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_standby_reset: assert property (
    standby_i |=> stat_q == `SSF_STAT_RESET)
    else $error("status not 0x84 after standby");

  a_flag_no_set: assert property (
    st_wr & ~tx_load_i & tx_en & ~rx_done_i & ~standby_i &
      ~dma_tx_write_i & ~dma_rx_read_i |=>
      stat_q[`SSF_BIT_TX_EMPTY:`SSF_BIT_PARITY] ==
      ($past(stat_q[`SSF_BIT_TX_EMPTY:`SSF_BIT_PARITY]) &
       ~$past(sw_clr)))
    else $error("status write changed flags wrongly");

  a_tx_finished_source: assert property (
    $rose(stat_q[`SSF_BIT_TX_DONE]) |->
      $past(tx_last_bit_i | ~tx_en | standby_i))
    else $error("tx finished rose without cause");

  a_tx_holding_empty_set: assert property (
    tx_load_i |=> stat_q[`SSF_BIT_TX_EMPTY])
    else $error("tx holding empty not set on load");

  a_dma_tx_fill: assert property (
    dma_tx_write_i & tx_en & ~tx_load_i & ~standby_i |=>
      !stat_q[`SSF_BIT_TX_EMPTY] && tx_hold_q == $past(dma_tx_data_i))
    else $error("dma write did not fill tx holding");

  a_full_set: assert property (
    rx_take & ~stat_q[`SSF_BIT_RX_FULL] & ~frm_err & ~par_err &
      ~standby_i |=> stat_q[`SSF_BIT_RX_FULL] &&
      rx_hold_q == $past(rx_data_i))
    else $error("rx holding full not set on clean frame");

  a_rx_holding_full_dma_clr: assert property (
    dma_rx_read_i & ~rx_take |=> ~stat_q[`SSF_BIT_RX_FULL])
    else $error("rx holding full not cleared by dma read");

  a_overrun_keep: assert property (
    rx_take & stat_q[`SSF_BIT_RX_FULL] & ~standby_i |=>
      stat_q[`SSF_BIT_OVERRUN] && $stable(rx_hold_q))
    else $error("overrun not flagged or byte lost");

  a_frame_copy: assert property (
    rx_take & ~stat_q[`SSF_BIT_RX_FULL] & frm_err & ~standby_i |=>
      stat_q[`SSF_BIT_FRAMING] && !stat_q[`SSF_BIT_RX_FULL] &&
      rx_hold_q == $past(rx_data_i))
    else $error("framing error handling wrong");

  a_halt_tie: assert property (
    ##1 rx_halt_o == (|stat_q[`SSF_BIT_OVERRUN:`SSF_BIT_PARITY]))
    else $error("rx halt does not follow error flags");

  a_halt_hold: assert property (
    rx_done_i & rx_halt_o & ~standby_i |=> $stable(rx_hold_q))
    else $error("rx holding byte changed while halted");

  a_clear_qual: assert property (
    $fell(stat_q[`SSF_BIT_OVERRUN]) |->
      $past(qual_q[`SSF_BIT_OVERRUN - `SSF_FLAG_LSB] | standby_i))
    else $error("overrun cleared without prior read");

endmodule // ssf_status_flags

// *** pkg/ssf_cfg.svh ***
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

// Register byte addresses on the APB port
`define SSF_ADDR_STATUS 12'h000
`define SSF_ADDR_CTRL 12'h004
`define SSF_ADDR_TXD 12'h008
`define SSF_ADDR_RXD 12'h00C

// Status register layout and reset value
`define SSF_STAT_RESET 8'h84
`define SSF_BIT_TX_EMPTY 7
`define SSF_BIT_RX_FULL 6
`define SSF_BIT_OVERRUN 5
`define SSF_BIT_FRAMING 4
`define SSF_BIT_PARITY 3
`define SSF_BIT_TX_DONE 2
`define SSF_BIT_RX_MP 1
`define SSF_BIT_TX_MP 0
`define SSF_FLAG_LSB 3
`define SSF_NFLAGS 5

// Control register layout and reset value
`define SSF_CTRL_W 6
`define SSF_CTRL_RESET 6'h00
`define SSF_CTRL_TX_EN 0
`define SSF_CTRL_RX_EN 1
`define SSF_CTRL_SYNC 2
`define SSF_CTRL_MPFMT 3
`define SSF_CTRL_PAREN 4
`define SSF_CTRL_PARODD 5

`define SSF_BYTE_ZERO 8'h00
`define SSF_WORD_ZERO 32'h0000_0000

`endif

// *** pkg/ssf_pkg.sv ***
package ssf_pkg;

  typedef logic [7:0] ssf_byte_t;

  typedef enum logic [2:0] {
    SSF_REG_STATUS = 3'b000,
    SSF_REG_CTRL = 3'b001,
    SSF_REG_TXD = 3'b010,
    SSF_REG_RXD = 3'b011,
    SSF_REG_NONE = 3'b100
  } ssf_reg_t;

endpackage

// *** testbench/ssf_remote_model.sv ***
`timescale 1ns/1ps

module ssf_remote_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench requests
  input wire logic go_i,
  input wire logic [10:0] frm_i,
  input wire logic xmit_i,
  input wire logic fin_i,
  // Shifter events toward the block
  output logic rx_done_o,
  output logic [10:0] frm_o,
  output logic tx_load_o,
  output logic tx_last_bit_o
);
  // Idle lines invert every cycle and rx_done_o pulses only with go_i, so a stale frame is never read as fresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_done_o <= 1'b0;
      frm_o <= 11'h7ff;
    end else begin
      rx_done_o <= go_i;
      frm_o <= go_i ? frm_i : ~frm_o;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_load_o <= 1'b0;
      tx_last_bit_o <= 1'b0;
    end else begin
      tx_load_o <= xmit_i;
      tx_last_bit_o <= fin_i;
    end
  end
endmodule // ssf_remote_model

// *** testbench/tb_ssf_status_flags.sv ***
`timescale 1ns/1ps
`include "ssf_cfg.svh"

module tb_ssf_status_flags;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stby = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, rd;
  logic prdy, perr, er, tld, tlb, tmpb, thalt, rdone, rhalt;
  logic [7:0] txd, rxd;
  logic [10:0] frm, frm_in = 11'h000;
  logic go = 1'b0, xmit = 1'b0, fin = 1'b0, dtw = 1'b0, drr = 1'b0;
  logic [7:0] dtd = 8'h00;
  logic [32:0] rows [4];
  int miscompares = 0;
  int checks_done = 0;

  always #20 clk_i = ~clk_i;

  ssf_status_flags u_ssf_status_flags (.clk_i(clk_i), .rst_i(rst_i),
    .standby_i(stby), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .tx_load_i(tld), .tx_last_bit_i(tlb),
    .tx_data_o(txd), .tx_mp_bit_o(tmpb), .tx_halt_o(thalt),
    .rx_done_i(rdone), .rx_data_i(frm[7:0]), .rx_parity_i(frm[8]),
    .rx_stop1_i(frm[9]), .rx_mp_bit_i(frm[10]), .rx_halt_o(rhalt),
    .dma_tx_write_i(dtw), .dma_tx_data_i(dtd), .dma_rx_read_i(drr),
    .rx_data_o(rxd));

  ssf_remote_model u_ssf_remote_model (.clk_i(clk_i), .rst_i(rst_i),
    .go_i(go), .frm_i(frm_in), .xmit_i(xmit), .fin_i(fin),
    .rx_done_o(rdone), .frm_o(frm), .tx_load_o(tld), .tx_last_bit_o(tlb));

  task end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      miscompares++;
      end_sim;
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task rdchk(input logic [7:0] e);
    apb(1'b0, `SSF_ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'(e), rd);
    chk("pslverr", 32'h0000_0000, 32'(er));
  endtask

  task frame(input logic [10:0] f);
    @(posedge clk_i);
    go <= 1'b1;
    frm_in <= f;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Pulse order: dma write, dma read, shifter load, last bit
  task pul(input logic [3:0] k);
    @(posedge clk_i);
    {dtw, drr, xmit, fin} <= k;
    @(posedge clk_i);
    {dtw, drr, xmit, fin} <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    rows[0] = {6'h0b, 11'h6a5, 8'hc7, 8'ha5};
    rows[1] = {6'h0b, 11'h43c, 8'h96, 8'h3c};
    rows[2] = {6'h1b, 11'h601, 8'h8e, 8'h01};
    rows[3] = {6'h3b, 11'h607, 8'hc6, 8'h07};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h84);
    apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_00ff);
    rdchk(8'h85);
    apb(1'b1, `SSF_ADDR_CTRL, 32'h0000_000b);
    rdchk(8'h85);
    chk("tx_mpb", 32'h0000_0001, 32'(tmpb));
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SSF_ADDR_CTRL, 32'(rows[i][32:27]));
      frame(rows[i][26:16]);
      rdchk(rows[i][15:8]);
      chk("rx_data", 32'(rows[i][7:0]), 32'(rxd));
      apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_0080);
      rdchk(8'h86);
    end
    $display("test frames done");
    apb(1'b1, `SSF_ADDR_CTRL, 32'h0000_0007);
    frame(11'h611);
    frame(11'h622);
    // Blind clear: no read has seen these flags yet
    apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_0080);
    rdchk(8'he6);
    chk("rx_halt", 32'h0000_0001, 32'(rhalt));
    chk("tx_halt", 32'h0000_0001, 32'(thalt));
    // Receiver off must leave every receive flag as it was
    apb(1'b1, `SSF_ADDR_CTRL, 32'h0000_0005);
    rdchk(8'he6);
    apb(1'b1, `SSF_ADDR_CTRL, 32'h0000_0007);
    frame(11'h633);
    chk("rx_data", 32'h0000_0011, 32'(rxd));
    apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_0080);
    rdchk(8'h86);
    $display("test overrun done");
    frame(11'h644);
    pul(4'h4);
    rdchk(8'h86);
    dtd <= 8'h5a;
    pul(4'h8);
    rdchk(8'h02);
    chk("tx_data", 32'h0000_005a, 32'(txd));
    pul(4'h2);
    rdchk(8'h82);
    pul(4'h1);
    rdchk(8'h86);
    $display("test dma done");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(er));
    chk("prdata", 32'h0000_0000, rd);
    apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_0081);
    @(posedge clk_i);
    stby <= 1'b1;
    @(posedge clk_i);
    stby <= 1'b0;
    rdchk(8'h84);
    $display("test standby done");
    apb(1'b1, `SSF_ADDR_CTRL, 32'h0000_000b);
    apb(1'b1, `SSF_ADDR_STATUS, 32'h0000_0081);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h84);
    chk("tx_mpb", 32'h0000_0000, 32'(tmpb));
    $display("test reset done");
    end_sim;
  end
endmodule // tb_ssf_status_flags
